// *** core/gpc_defs.svh ***
// constants for the global pin control block: offsets, fields, resets, timing
`ifndef GPC_DEFS_SVH
`define GPC_DEFS_SVH

`define GPC_NUM_CH        29
`define GPC_NUM_IRQ       8
`define GPC_NUM_GPIO      2
`define GPC_NUM_SYNC      10

// register byte offsets (haddr[11:0])
`define GPC_OFF_GCFG      12'h000
`define GPC_OFF_GPIO      12'h004
`define GPC_OFF_IMASK     12'h008
`define GPC_OFF_STAT      12'h00C
`define GPC_OFF_CHAN_LO   12'h100
`define GPC_OFF_CHAN_HI   12'h170
`define GPC_ADDR_W        12

// field positions
`define GPC_CHAN_T1       0
`define GPC_GCFG_INT_HI   2
`define GPC_GCFG_INT_PP   3
`define GPC_GPIO_DIR_LSB  0
`define GPC_GPIO_LVL_LSB  2

// reset values
`define GPC_GCFG_RST      4'h0
`define GPC_IMASK_RST     8'hFF
`define GPC_CHAN_RST      8'h00

// synchroniser bit positions and their reset levels (pulled-up pins and chip select high)
`define GPC_SY_OE         0
`define GPC_SY_HWEN       1
`define GPC_SY_HWSEL      2
`define GPC_SY_GPIO       3
`define GPC_SY_PS         5
`define GPC_SY_STYLE      6
`define GPC_SY_MUX        7
`define GPC_SY_CS         8
`define GPC_SY_SCLK       9
`define GPC_SYNC_RST      10'h1C6

// hardware reset time, longest figure, rounded down to clock cycles
`define GPC_RST_TIME_NS   2000
`define GPC_CLK_NS        100
`define GPC_RST_CYCLES    ((`GPC_RST_TIME_NS) / (`GPC_CLK_NS))
`define GPC_RST_CNT_W     5

`endif

// *** core/gpc_pkg.sv ***
// types shared by the global pin control block
package gpc_pkg;

   typedef enum logic [0:0] {RST_HOLD, RST_DONE} gpc_rst_state_t;

   typedef struct packed {
      logic serial;      // serial host port selected
      logic sepStrobe;   // separate read and write strobes
      logic addrMux;     // multiplexed address/data bus
   } gpc_host_mode_t;

   typedef struct packed {
      logic serialPins;    // chip select, shift clock, serial_data_in, serial_data_out
      logic parallelPins;  // data, address, strobes, address_latch_strobe, acknowledge
   } gpc_pin_use_t;

endpackage : gpc_pkg

// *** core/gpc_sync.sv ***
// two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module gpc_sync #(
   parameter int          W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_r;

   // meta_r feeds only the second stage
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_r <= RST_VAL;
         dout   <= RST_VAL;
      end else begin
         meta_r <= din;
         dout   <= meta_r;
      end
   end
endmodule : gpc_sync
`default_nettype wire

// *** core/gpc_top.sv ***
// global pin control and host port select, registers on ahb-lite
`include "gpc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module gpc_top import gpc_pkg::*; (
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   // ahb-lite slave
   input  wire logic                     hsel,
   input  wire logic [31:0]              haddr,
   input  wire logic [1:0]               htrans,
   input  wire logic                     hwrite,
   input  wire logic [2:0]               hsize,
   input  wire logic [31:0]              hwdata,
   input  wire logic                     hready,
   output logic                          hreadyout,
   output logic                          hresp,
   output logic      [31:0]              hrdata,
   // line drivers and line standard
   input  wire logic                     globalDrvEnable,
   input  wire logic [`GPC_NUM_CH-1:0]   drvCfgEn,
   output logic      [`GPC_NUM_CH-1:0]   lineDrvOe,
   input  wire logic                     hw_line_mode_select_enable,
   input  wire logic                     hw_line_mode_select,
   output logic      [`GPC_NUM_CH-1:0]   lineModeT1,
   // general purpose pins
   input  wire logic [`GPC_NUM_GPIO-1:0] gpioIn,
   output logic      [`GPC_NUM_GPIO-1:0] gpioOut,
   output logic      [`GPC_NUM_GPIO-1:0] gpioOe,
   // interrupt pin
   input  wire logic [`GPC_NUM_IRQ-1:0]  irqSrc,
   output logic                          irqOut,
   output logic                          irqOe,
   // host port pins and straps
   input  wire logic                     hostSelect_n,
   input  wire logic                     shiftClk,
   input  wire logic                     hostPortParallel,
   input  wire logic                     parallel_bus_style_select,
   input  wire logic                     address_multiplex_select,
   output gpc_host_mode_t                hostMode,
   output gpc_pin_use_t                  pinUse,
   output logic                          hostSelActive,
   output logic                          hostAccessStart,
   output logic                          serialSampleStb,
   output logic                          serialShiftStb,
   output logic                          resetDone
);
   localparam int RST_CYC_I = `GPC_RST_CYCLES + 1;

   // address decode helpers, shared by the read and write paths
   function automatic logic isChan(input logic [`GPC_ADDR_W-1:0] a);
      isChan = (a >= `GPC_OFF_CHAN_LO) && (a <= `GPC_OFF_CHAN_HI);
   endfunction : isChan

   function automatic logic [4:0] chanIdx(input logic [`GPC_ADDR_W-1:0] a);
      logic [`GPC_ADDR_W-1:0] d;
      d       = a - `GPC_OFF_CHAN_LO;
      chanIdx = d[6:2];
   endfunction : chanIdx

   // ---------------- synchronisers ----------------
   logic [`GPC_NUM_SYNC-1:0] syncIn;
   logic [`GPC_NUM_SYNC-1:0] syncOut;

   assign syncIn = {shiftClk, hostSelect_n, address_multiplex_select,
                    parallel_bus_style_select, hostPortParallel, gpioIn,
                    hw_line_mode_select, hw_line_mode_select_enable, globalDrvEnable};

   gpc_sync #(.W(`GPC_NUM_SYNC), .RST_VAL(`GPC_SYNC_RST)) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .din   (syncIn),
      .dout  (syncOut)
   );

   wire                     oeSync    = syncOut[`GPC_SY_OE];
   wire                     hwEnSync  = syncOut[`GPC_SY_HWEN];
   wire                     hwSelSync = syncOut[`GPC_SY_HWSEL];
   wire [`GPC_NUM_GPIO-1:0] gpioSync  = syncOut[`GPC_SY_GPIO +: `GPC_NUM_GPIO];
   wire                     csSync_n  = syncOut[`GPC_SY_CS];
   wire                     sclkSync  = syncOut[`GPC_SY_SCLK];

   // ---------------- reset sequence ----------------
   gpc_rst_state_t             rstState_r;
   logic [`GPC_RST_CNT_W-1:0]  rstCnt_r;
   localparam int              RST_CNT_BITS = `GPC_RST_CNT_W;
   wire                        rstLast = (rstCnt_r == RST_CNT_BITS'(`GPC_RST_CYCLES - 1));

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rstState_r <= RST_HOLD;
         rstCnt_r   <= '0;
      end else begin
         case (rstState_r)
            RST_HOLD: begin
               rstCnt_r <= rstCnt_r + 1'b1;
               if (rstLast) begin
                  rstState_r <= RST_DONE;
               end
            end
            RST_DONE: rstCnt_r <= rstCnt_r;
            default:  rstState_r <= RST_HOLD;
         endcase
      end
   end

   assign resetDone = (rstState_r == RST_DONE);

   // straps are caught once at the end of the reset sequence so they cannot glitch the port
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hostMode <= '0;
      end else if (rstState_r == RST_HOLD && rstLast) begin
         hostMode.serial    <= !syncOut[`GPC_SY_PS];
         hostMode.sepStrobe <= syncOut[`GPC_SY_STYLE];
         hostMode.addrMux   <= syncOut[`GPC_SY_MUX];
      end
   end

   // pin group enables follow the selected port type
   assign pinUse.serialPins   = resetDone && hostMode.serial;
   assign pinUse.parallelPins = resetDone && !hostMode.serial;

   // ---------------- host select qualification ----------------
   logic csPrev_n_r;
   logic sclkPrev_r;
   wire  csFell  = csPrev_n_r && !csSync_n;
   wire  sclkUp  = sclkSync && !sclkPrev_r;
   wire  sclkDn  = !sclkSync && sclkPrev_r;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         csPrev_n_r      <= 1'b1;
         sclkPrev_r      <= 1'b0;
         hostSelActive   <= 1'b0;
         hostAccessStart <= 1'b0;
         serialSampleStb <= 1'b0;
         serialShiftStb  <= 1'b0;
      end else begin
         csPrev_n_r      <= csSync_n;
         sclkPrev_r      <= sclkSync;
         hostSelActive   <= resetDone && !csSync_n;
         hostAccessStart <= resetDone && csFell;
         serialSampleStb <= pinUse.serialPins && !csSync_n && sclkUp;
         serialShiftStb  <= pinUse.serialPins && !csSync_n && sclkDn;
      end
   end

   // ---------------- ahb-lite slave ----------------
   logic                   wrPend_r;
   logic [`GPC_ADDR_W-1:0] wrAddr_r;
   logic [3:0]             gcfg_r;
   logic [1:0]             gpioDir_r;
   logic [1:0]             gpioLvl_r;
   logic [7:0]             imask_r;
   logic [7:0]             chan_r [`GPC_NUM_CH];

   wire                    addrPhase = hsel && htrans[1] && hready;
   wire [`GPC_ADDR_W-1:0]  aAddr     = haddr[`GPC_ADDR_W-1:0];
   wire                    wrGcfg    = wrPend_r && (wrAddr_r == `GPC_OFF_GCFG);
   wire                    wrGpio    = wrPend_r && (wrAddr_r == `GPC_OFF_GPIO);
   wire                    wrImask   = wrPend_r && (wrAddr_r == `GPC_OFF_IMASK);
   wire                    wrChan    = wrPend_r && isChan(wrAddr_r);
   wire [4:0]              wrIdx     = chanIdx(wrAddr_r);

   // an input pin reads back its sampled level, an output pin its stored level
   wire [1:0]  gpioView = (gpioDir_r & gpioLvl_r) | (~gpioDir_r & gpioSync);
   wire        irqAny   = |(irqSrc & ~imask_r);
   wire [31:0] statWord = {16'h0000, irqSrc, irqAny, hwSelSync, hwEnSync, oeSync,
                           hostMode.addrMux, hostMode.sepStrobe, hostMode.serial, resetDone};
   wire [4:0]  rdIdx    = chanIdx(aAddr);
   wire [31:0] rdMux    = isChan(aAddr)                ? {24'h000000, chan_r[rdIdx]} :
                          (aAddr == `GPC_OFF_GCFG)     ? {28'h0000000, gcfg_r} :
                          (aAddr == `GPC_OFF_GPIO)     ? {28'h0000000, gpioView, gpioDir_r} :
                          (aAddr == `GPC_OFF_IMASK)    ? {24'h000000, imask_r} :
                          (aAddr == `GPC_OFF_STAT)     ? statWord : 32'h00000000;

   // zero wait states; hsize is ignored since only whole words are used
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wrPend_r <= 1'b0;
         wrAddr_r <= '0;
         hrdata   <= 32'h00000000;
      end else begin
         wrPend_r <= addrPhase && hwrite;
         wrAddr_r <= aAddr;
         if (addrPhase && !hwrite) begin
            hrdata <= rdMux;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         gcfg_r    <= `GPC_GCFG_RST;
         gpioDir_r <= '0;
         gpioLvl_r <= '0;
         imask_r   <= `GPC_IMASK_RST;
      end else begin
         if (wrGcfg) gcfg_r <= hwdata[3:0];
         if (wrGpio) begin
            gpioDir_r <= hwdata[`GPC_GPIO_DIR_LSB +: `GPC_NUM_GPIO];
            gpioLvl_r <= hwdata[`GPC_GPIO_LVL_LSB +: `GPC_NUM_GPIO];
         end
         if (wrImask) imask_r <= hwdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < `GPC_NUM_CH; i++) chan_r[i] <= `GPC_CHAN_RST;
      end else if (wrChan) begin
         chan_r[wrIdx] <= hwdata[7:0];
      end
   end

   // ---------------- pin outputs ----------------
   logic [`GPC_NUM_CH-1:0] chanT1;
   always_comb begin
      for (int i = 0; i < `GPC_NUM_CH; i++) chanT1[i] = chan_r[i][`GPC_CHAN_T1];
   end

   // hardware select wins over the channel bits; the mode pin is don't-care otherwise
   wire [`GPC_NUM_CH-1:0] modeNxt = hwEnSync ? {`GPC_NUM_CH{hwSelSync}} : chanT1;
   wire                   intHi   = gcfg_r[`GPC_GCFG_INT_HI];
   wire                   intPp   = gcfg_r[`GPC_GCFG_INT_PP];
   wire                   irqLvl  = intHi ? irqAny : !irqAny;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lineDrvOe  <= '0;
         lineModeT1 <= '0;
         irqOut     <= 1'b0;
         irqOe      <= 1'b0;
      end else begin
         // only the driver enables and the status word see the global pin; nothing else depends on it
         lineDrvOe  <= drvCfgEn & {`GPC_NUM_CH{oeSync}};
         lineModeT1 <= modeNxt;
         // open drain can only pull low, so it drives just when the wanted level is low
         irqOut     <= intPp ? irqLvl : 1'b0;
         irqOe      <= intPp || !irqLvl;
      end
   end

   assign gpioOut = gpioLvl_r;
   assign gpioOe  = gpioDir_r;

   // ---------------- assertions ----------------
   AST_DRV_OFF: assert property (@(posedge clk) disable iff (!rst_n)
      !oeSync |=> lineDrvOe == '0) else $error("drivers on while global enable low");
   AST_DRV_PASS: assert property (@(posedge clk) disable iff (!rst_n)
      oeSync |=> lineDrvOe == $past(drvCfgEn)) else $error("driver enables not passed");
   AST_MODE_HW: assert property (@(posedge clk) disable iff (!rst_n)
      hwEnSync |=> lineModeT1 == {`GPC_NUM_CH{$past(hwSelSync)}})
      else $error("line mode not from hardware pin");
   AST_MODE_CH: assert property (@(posedge clk) disable iff (!rst_n)
      !hwEnSync |=> lineModeT1 == $past(chanT1)) else $error("line mode not from channel bit");
   AST_GPIO_WR: assert property (@(posedge clk) disable iff (!rst_n)
      wrGpio |=> gpioOut == $past(hwdata[3:2]) && gpioOe == $past(hwdata[1:0]))
      else $error("gpio write not applied");
   AST_GPIO_RD: assert property (@(posedge clk) disable iff (!rst_n)
      addrPhase && !hwrite && aAddr == `GPC_OFF_GPIO && gpioDir_r == 2'h0 && !wrGpio
      |=> hrdata[3:2] == $past(gpioSync)) else $error("gpio input level not read back");
   AST_IRQ_PP: assert property (@(posedge clk) disable iff (!rst_n)
      irqAny && intPp && intHi && !wrGcfg |=> irqOut && irqOe)
      else $error("push-pull high irq not asserted");
   AST_IRQ_OD: assert property (@(posedge clk) disable iff (!rst_n)
      !intPp && !intHi && !wrGcfg ##0 (irqSrc & ~imask_r) == '0 && !wrImask
      |=> !irqOe) else $error("open drain irq driven while idle");
   AST_RST_TIME: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(rst_n) |-> ##[1:RST_CYC_I] resetDone) else $error("reset sequence too long");
   AST_HOST_BLOCK: assert property (@(posedge clk) disable iff (!rst_n)
      !resetDone |=> !hostSelActive && !hostAccessStart) else $error("host access in reset");
   AST_HOST_START: assert property (@(posedge clk) disable iff (!rst_n)
      hostAccessStart |-> hostSelActive && $past(csPrev_n_r))
      else $error("access start without select fall");

   COV_RST_DONE: cover property (@(posedge clk) disable iff (!rst_n) $rose(resetDone));
   COV_HOST_START: cover property (@(posedge clk) disable iff (!rst_n) hostAccessStart);
   COV_DRV_CUT: cover property (@(posedge clk) disable iff (!rst_n)
      oeSync ##1 !oeSync ##1 lineDrvOe == '0);
   COV_IRQ: cover property (@(posedge clk) disable iff (!rst_n) irqAny && irqOe);
endmodule : gpc_top
`default_nettype wire

// *** dv/gpc_host_model.sv ***
// host processor model: chip select framing and serial shift clock
`timescale 1ns/1ps
`default_nettype none
module gpc_host_model (
   input  wire logic       clk,
   input  wire logic       req,
   input  wire logic [3:0] nClk,
   input  wire logic [3:0] halfCyc,
   output logic            hostSelect_n,
   output logic            shiftClk,
   output logic            busy
);
   int i;
   // one process owns the pins; shift clock stands low outside frames
   initial begin
      hostSelect_n = 1'h1;
      shiftClk     = 1'h0;
      busy         = 1'h0;
      forever begin
         @(posedge clk);
         if (req === 1'h1) begin
            busy         <= 1'h1;
            hostSelect_n <= 1'h0;
            repeat (halfCyc) @(posedge clk);
            for (i = 0; i < nClk; i++) begin
               shiftClk <= 1'h1;
               repeat (halfCyc) @(posedge clk);
               shiftClk <= 1'h0;
               repeat (halfCyc) @(posedge clk);
            end
            // select rises after every access so the next one starts with a fresh fall
            hostSelect_n <= 1'h1;
            repeat (halfCyc) @(posedge clk);
            busy <= 1'h0;
         end
      end
   end
endmodule : gpc_host_model
`default_nettype wire

// *** dv/gpc_top_tb.sv ***
// self-checking testbench for the global pin control block
`include "gpc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module gpc_top_tb import gpc_pkg::*;;
   logic                   clk, rst_n, hsel, hwrite, hreadyout, hresp, globalDrvEnable;
   logic                   hw_line_mode_select_enable, hw_line_mode_select, irqOut, irqOe;
   logic                   hostPortParallel, parallel_bus_style_select, address_multiplex_select;
   logic                   hostSelect_n, shiftClk, hostReq, hostBusy, hostSelActive, resetDone;
   logic                   hostAccessStart, serialSampleStb, serialShiftStb, lvl, expOe;
   logic [1:0]             htrans, gpioExt, gpioOut, gpioOe;
   logic [2:0]             hsize;
   logic [3:0]             nClk, halfCyc;
   logic [7:0]             irqSrc;
   logic [31:0]            haddr, hwdata, hrdata, rd;
   logic [`GPC_NUM_CH-1:0] drvCfgEn, lineDrvOe, lineModeT1;
   gpc_host_mode_t         hostMode;
   gpc_pin_use_t           pinUse;
   int                     mismatches, samples_checked, cntAcc, cntSmp, cntShf, g, a, c0, c1;
   wire logic              hready = hreadyout;
   // gpio pin level resolved from both drivers
   wire logic [1:0]        gpioIn = (gpioOe & gpioOut) | (~gpioOe & gpioExt);

   gpc_top u_dut (
      .clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
      .hresp, .hrdata, .globalDrvEnable, .drvCfgEn, .lineDrvOe, .hw_line_mode_select_enable,
      .hw_line_mode_select, .lineModeT1, .gpioIn, .gpioOut, .gpioOe, .irqSrc, .irqOut, .irqOe,
      .hostSelect_n, .shiftClk, .hostPortParallel, .parallel_bus_style_select,
      .address_multiplex_select, .hostMode, .pinUse, .hostSelActive, .hostAccessStart,
      .serialSampleStb, .serialShiftStb, .resetDone
   );
   gpc_host_model u_host (.clk, .req(hostReq), .nClk, .halfCyc, .hostSelect_n, .shiftClk,
      .busy(hostBusy));

   initial clk = 1'h0;
   always #50 clk = ~clk;

   // pulses counted on the falling edge so the main sequence never races them
   always @(negedge clk) begin
      if (hostAccessStart === 1'h1) cntAcc++;
      if (serialSampleStb === 1'h1) cntSmp++;
      if (serialShiftStb === 1'h1) cntShf++;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic stop_test();
      $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : stop_test

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'h1 && n < 50);
      if (n >= 50) mismatches++;
   endtask : wait_ready

   task automatic xfer(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
      hsel   <= 1'h1;
      htrans <= 2'h2;
      haddr  <= {20'h0, ad};
      hwrite <= wr;
      wait_ready();
      hsel   <= 1'h0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
      check(hresp, 32'h0);
   endtask : xfer

   task automatic rdchk(input logic [11:0] ad, input logic [31:0] exp);
      xfer(1'h0, ad, 32'h0);
      check(rd, exp);
   endtask : rdchk

   task automatic host_access(input logic [3:0] n, input logic [3:0] h);
      int k;
      nClk    <= n;
      halfCyc <= h;
      hostReq <= 1'h1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (hostBusy !== 1'h1 && k < 20);
      if (k >= 20) mismatches++;
      hostReq <= 1'h0;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (hostBusy !== 1'h0 && k < 400);
      if (k >= 400) mismatches++;
   endtask : host_access

   // straps are held through reset; the host tries an access before reset completes
   task automatic do_reset(input logic p, input logic s, input logic m);
      rst_n                     <= 1'h0;
      hostPortParallel          <= p;
      parallel_bus_style_select <= s;
      address_multiplex_select  <= m;
      repeat (16) @(posedge clk);
      rst_n <= 1'h1;
      c0 = cntAcc;
      fork
         begin
            repeat (19) @(posedge clk);
            #1;
            check(resetDone, 32'h0);
            @(posedge clk);
            #1;
            check(resetDone, 32'h1);
         end
         host_access(4'h1, 4'h2);
      join
      @(posedge clk);
      check(cntAcc - c0, 32'h0);
      rdchk(`GPC_OFF_IMASK, 32'hFF);
   endtask : do_reset

   initial begin
      hsel = 1'h0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
      globalDrvEnable = 1'h1;
      drvCfgEn = '0;
      hw_line_mode_select_enable = 1'h1;
      hw_line_mode_select = 1'h1;
      gpioExt = 2'h0;
      irqSrc = 8'h0;
      hostReq = 1'h0;
      nClk = 4'h1;
      halfCyc = 4'h2;
      do_reset(1'h0, 1'h1, 1'h0);
      check(hostMode, 32'h6);
      check(pinUse, 32'h2);
      rdchk(`GPC_OFF_STAT, 32'h77);
      rdchk(`GPC_OFF_GCFG, 32'h0);
      rdchk(`GPC_OFF_GPIO, 32'h0);
      rdchk(`GPC_OFF_CHAN_HI, 32'h0);
      xfer(1'h1, 12'h080, 32'hFFFFFFFF);
      rdchk(12'h080, 32'h0);
      host_access(4'h5, 4'h3);
      host_access(4'h8, 4'h6);
      cyc(4);
      check({cntAcc[7:0], cntSmp[7:0], cntShf[7:0]}, 32'h020D0D);
      check(hostSelActive, 32'h0);
      drvCfgEn <= 29'h15555555;
      cyc(4);
      check(lineDrvOe, 32'h15555555);
      drvCfgEn <= 29'h0AAAAAAA;
      cyc(4);
      check(lineDrvOe, 32'h0AAAAAAA);
      globalDrvEnable <= 1'h0;
      cyc(4);
      check(lineDrvOe, 32'h0);
      // the line mode and gpio checks below run with the drivers forced off
      hw_line_mode_select <= 1'h0;
      cyc(4);
      check(lineModeT1, 32'h0);
      hw_line_mode_select <= 1'h1;
      cyc(4);
      check(lineModeT1, 32'h1FFFFFFF);
      xfer(1'h1, `GPC_OFF_CHAN_LO, 32'h1);
      xfer(1'h1, `GPC_OFF_CHAN_HI, 32'h1);
      hw_line_mode_select_enable <= 1'h0;
      cyc(4);
      check(lineModeT1, 32'h10000001);
      hw_line_mode_select <= 1'h0;
      cyc(4);
      check(lineModeT1, 32'h10000001);
      xfer(1'h1, `GPC_OFF_GPIO, 32'h9);
      gpioExt <= 2'h3;
      cyc(4);
      check({gpioOe, gpioOut}, 32'h6);
      rdchk(`GPC_OFF_GPIO, 32'h9);
      gpioExt <= 2'h1;
      cyc(4);
      rdchk(`GPC_OFF_GPIO, 32'h1);
      xfer(1'h1, `GPC_OFF_GPIO, 32'h6);
      gpioExt <= 2'h0;
      cyc(4);
      check({gpioOe, gpioOut}, 32'h9);
      rdchk(`GPC_OFF_GPIO, 32'h2);
      globalDrvEnable <= 1'h1;
      cyc(4);
      check(lineDrvOe, 32'h0AAAAAAA);
      irqSrc <= 8'hFF;
      cyc(4);
      check(irqOe, 32'h0);
      xfer(1'h1, `GPC_OFF_IMASK, 32'hFE);
      // every drive type and polarity, with the source pending and masked
      for (g = 0; g < 4; g++) begin
         for (a = 0; a < 2; a++) begin
            xfer(1'h1, `GPC_OFF_GCFG, 32'(g) << 2);
            irqSrc <= (a == 1) ? 8'h01 : 8'h02;
            cyc(4);
            lvl = (a == 1) ? g[0] : ~g[0];
            expOe = g[1] | ~lvl;
            check({irqOe, irqOe ? irqOut : 1'h1}, {expOe, lvl});
         end
      end
      for (g = 0; g < 2; g++) begin
         do_reset(1'h1, g[0], ~g[0]);
         check(hostMode, {29'h0, 1'h0, g[0], ~g[0]});
         check(pinUse, 32'h1);
         rdchk(`GPC_OFF_STAT, {16'h0000, 8'h01, 4'h1, ~g[0], g[0], 1'h0, 1'h1});
         c0 = cntAcc;
         c1 = cntSmp;
         host_access(4'h3, 4'h3);
         cyc(4);
         check(cntAcc - c0, 32'h1);
         check(cntSmp - c1, 32'h0);
      end
      stop_test();
   end

   // the whole sequence needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      stop_test();
   end
endmodule : gpc_top_tb
`default_nettype wire
